/* File: uswcc_ctrl.sv */
// Pin control, clock source and counter logic of the universal serial unit
module uswcc_ctrl
   import uswcc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [1:0] wire_mode_select,
   input wire logic [1:0] clock_source_select,
   input wire logic clock_strobe_select,
   input wire logic clock_strobe_write,
   input wire logic clock_toggle_strobe,
   input wire logic timer_compare_match,
   input wire logic data_reg_wr,
   input wire logic [7:0] data_reg_wdata,
   input wire logic counter_wr,
   input wire logic [3:0] counter_wdata,
   input wire logic start_flag_clr,
   input wire logic overflow_flag_clr,
   input wire logic port_do_latch,
   input wire logic port_do_dir,
   input wire logic port_sda_latch,
   input wire logic port_sda_dir,
   input wire logic port_scl_latch,
   input wire logic port_scl_dir,
   input wire logic sda_in,
   input wire logic scl_in,
   output logic [7:0] data_reg_value,
   output logic [3:0] four_bit_counter,
   output logic start_condition_flag,
   output logic counter_overflow_flag,
   output logic do_out,
   output logic do_oe,
   output logic do_pullup,
   output logic sda_out,
   output logic sda_oe,
   output logic sda_pullup,
   output logic scl_out,
   output logic scl_oe,
   output logic scl_pullup
);

   uswcc_state_t st_r;
   uswcc_state_t st_nxt;

   logic [USWCC_NUM_SYNC-1:0] pin_raw;
   logic [USWCC_NUM_SYNC-1:0] pin_level;

   assign pin_raw[USWCC_SYNC_SDA] = sda_in;
   assign pin_raw[USWCC_SYNC_SCL] = scl_in;

   // Inputs are sampled in every wire mode
   generate
      for (genvar i = 0; i < USWCC_NUM_SYNC; i++) begin : g_sync
         uswcc_pin_sync u_sync (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .pin_async(pin_raw[i]),
            .level_q(pin_level[i])
         );
      end
   endgenerate

   // True for the two open-drain wire modes
   function automatic logic is_two_wire(input logic [1:0] wm);
      is_two_wire = wm[USWCC_WM_TWO_BIT];
   endfunction

   // True when the pin clock edge detector is the clock source
   function automatic logic is_pin_clock(input logic [1:0] cs, input logic sel);
      is_pin_clock = cs[USWCC_CS_EXT_BIT] && !sel;
   endfunction

   logic sda_f;
   logic scl_f;
   logic scl_rise;
   logic scl_fall;
   logic sample_edge;
   logic update_edge;
   logic shift_clk;
   logic start_seen;
   logic scl_hold;
   logic dout_eff;
   logic two_wire;
   logic pin_clk;

   always_comb begin
      sda_f = pin_level[USWCC_SYNC_SDA];
      scl_f = pin_level[USWCC_SYNC_SCL];
      scl_rise = scl_f && !st_r.scl_prev;
      scl_fall = !scl_f && st_r.scl_prev;
      two_wire = is_two_wire(wire_mode_select);
      pin_clk = is_pin_clock(clock_source_select, clock_strobe_select);
      // Sampling edge is rising when bit 0 of the source code is clear, falling when it is set
      if (clock_source_select[USWCC_CS_NEG_BIT]) begin
         sample_edge = scl_fall;
         update_edge = scl_rise;
      end else begin
         sample_edge = scl_rise;
         update_edge = scl_fall;
      end
      shift_clk = 1'b0;
      // [R16] Pin clock works regardless of mode
      // [R15] Selected source clocks counter
      case (clock_source_select)
         USWCC_CS_SOFT: begin
            // [R13] Strobe write clocks once
            shift_clk = clock_strobe_write && clock_strobe_select;
         end
         USWCC_CS_TIMER: begin
            shift_clk = timer_compare_match;
         end
         USWCC_CS_EXT_POS, USWCC_CS_EXT_NEG: begin
            // [R14] Select bit picks toggle strobe
            if (clock_strobe_select) begin
               shift_clk = clock_toggle_strobe;
            end else begin
               shift_clk = sample_edge;
            end
         end
         default: begin
            shift_clk = 1'b0;
         end
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.sda_prev = sda_f;
      st_nxt.scl_prev = scl_f;

      // Data register: software write wins over a shift
      if (data_reg_wr) begin
         st_nxt.data = data_reg_wdata;
      end else if (shift_clk) begin
         st_nxt.data = {st_r.data[USWCC_MSB-1:0], sda_f};
      end

      // [R17] Counter wraps and sets overflow
      if (counter_wr) begin
         st_nxt.cnt = counter_wdata;
      end else if (shift_clk) begin
         st_nxt.cnt = st_r.cnt + USWCC_CNT_ONE;
      end
      if (overflow_flag_clr) begin
         st_nxt.ovf_flag = 1'b0;
      end
      if (!counter_wr && shift_clk && (st_r.cnt == USWCC_CNT_MAX)) begin
         st_nxt.ovf_flag = 1'b1;
      end

      // [R8] Start condition sets flag; set beats clear
      // [R1] Start detector only in the two-wire modes 10 and 11
      start_seen = two_wire && scl_f && st_r.sda_prev && !sda_f;
      if (start_flag_clr) begin
         st_nxt.start_flag = 1'b0;
      end
      if (start_seen) begin
         st_nxt.start_flag = 1'b1;
      end

      // [R11] Output latch moves on the edge opposite to sampling
      if (pin_clk && update_edge) begin
         st_nxt.dout_latch = st_r.data[USWCC_MSB];
      end
      // [R12] Transparent latch for strobe and timer sources
      if (pin_clk) begin
         dout_eff = st_r.dout_latch;
      end else begin
         dout_eff = st_nxt.data[USWCC_MSB];
      end

      // [R8] Start hold of SCL
      // [R10] Overflow hold in mode 11
      scl_hold = st_nxt.start_flag
         || ((wire_mode_select == USWCC_WM_TWO_OVF) && st_nxt.ovf_flag);

      // Data output pin: ordinary port unless three-wire
      st_nxt.do_oe = port_do_dir;
      st_nxt.do_pu = !port_do_dir && port_do_latch;
      if (wire_mode_select == USWCC_WM_THREE) begin
         // [R2] Serial data replaces latch bit
         st_nxt.do_out = dout_eff;
      end else begin
         // [R1] Ordinary port operation
         st_nxt.do_out = port_do_latch;
      end

      if (two_wire) begin
         // [R5] Open-drain drivers gated by direction
         // [R6] SDA low on data or latch zero
         st_nxt.sda_out = 1'b0;
         st_nxt.sda_oe = port_sda_dir && (!dout_eff || !port_sda_latch);
         // [R7] SCL low on latch zero or hold
         st_nxt.scl_out = 1'b0;
         st_nxt.scl_oe = port_scl_dir && (!port_scl_latch || scl_hold);
         // [R9] Pull-ups off in two-wire mode
         st_nxt.sda_pu = 1'b0;
         st_nxt.scl_pu = 1'b0;
      end else begin
         // [R3] Data-in and clock pins act as plain port
         // [R1] No hold, no drive override
         st_nxt.sda_out = port_sda_latch;
         st_nxt.sda_oe = port_sda_dir;
         st_nxt.sda_pu = !port_sda_dir && port_sda_latch;
         st_nxt.scl_out = port_scl_latch;
         st_nxt.scl_oe = port_scl_dir;
         st_nxt.scl_pu = !port_scl_dir && port_scl_latch;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         st_r <= USWCC_STATE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign data_reg_value = st_r.data;
   assign four_bit_counter = st_r.cnt;
   assign start_condition_flag = st_r.start_flag;
   assign counter_overflow_flag = st_r.ovf_flag;
   assign do_out = st_r.do_out;
   assign do_oe = st_r.do_oe;
   assign do_pullup = st_r.do_pu;
   assign sda_out = st_r.sda_out;
   assign sda_oe = st_r.sda_oe;
   assign sda_pullup = st_r.sda_pu;
   assign scl_out = st_r.scl_out;
   assign scl_oe = st_r.scl_oe;
   assign scl_pullup = st_r.scl_pu;

endmodule

/* File: uswcc_ctrl_sva.sv */
// Port checker for the serial wire clock control block
module uswcc_ctrl_sva
   import uswcc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [1:0] wire_mode_select,
   input wire logic [1:0] clock_source_select,
   input wire logic clock_strobe_select,
   input wire logic clock_strobe_write,
   input wire logic timer_compare_match,
   input wire logic counter_wr,
   input wire logic start_flag_clr,
   input wire logic overflow_flag_clr,
   input wire logic port_do_dir,
   input wire logic port_sda_latch,
   input wire logic port_sda_dir,
   input wire logic port_scl_latch,
   input wire logic port_scl_dir,
   input wire logic [3:0] four_bit_counter,
   input wire logic start_condition_flag,
   input wire logic counter_overflow_flag,
   input wire logic do_oe,
   input wire logic sda_oe,
   input wire logic sda_pullup,
   input wire logic scl_oe,
   input wire logic scl_pullup
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   logic live_r;
   always_ff @(posedge ref_clk) begin
      live_r <= reset_n;
   end
   a_off_silent: assert property (live_r && $past(wire_mode_select == 2'h0 && !port_sda_dir
      && !port_scl_dir) |-> !sda_oe && !scl_oe && !$rose(start_condition_flag))
      else $error("unit active in off mode");
   a_three_dir: assert property (live_r && $past(wire_mode_select) == 2'h1
      |-> do_oe == $past(port_do_dir)) else $error("data out direction wrong");
   a_two_no_pullup: assert property (live_r && $past(wire_mode_select[1])
      |-> !sda_pullup && !scl_pullup) else $error("pull-up on in two-wire mode");
   a_sda_pull_low: assert property (live_r
      && $past(wire_mode_select[1] && port_sda_dir && !port_sda_latch) |-> sda_oe)
      else $error("sda not pulled low");
   a_scl_latch_low: assert property (live_r
      && $past(wire_mode_select[1] && port_scl_dir && !port_scl_latch) |-> scl_oe)
      else $error("scl not pulled low");
   a_scl_release: assert property (live_r && $past(wire_mode_select == 2'h2
      && port_scl_dir && port_scl_latch) && !start_condition_flag |-> !scl_oe)
      else $error("scl not released");
   a_start_hold: assert property (live_r && $past(wire_mode_select[1] && port_scl_dir
      && start_condition_flag && !start_flag_clr) |-> scl_oe) else $error("no start hold");
   a_ovf_hold: assert property (live_r && $past(wire_mode_select == 2'h3 && port_scl_dir
      && counter_overflow_flag && !overflow_flag_clr) |-> scl_oe) else $error("no ovf hold");
   a_soft_count: assert property (live_r && $past(!counter_wr && (clock_source_select == 2'h0
      && clock_strobe_select && clock_strobe_write || clock_source_select == 2'h1
      && timer_compare_match)) |-> four_bit_counter == $past(four_bit_counter) + 4'h1)
      else $error("counter missed a clock");
   a_wrap_flag: assert property (live_r && $past(four_bit_counter) == 4'hF
      && four_bit_counter == 4'h0 && !$past(counter_wr) |-> counter_overflow_flag)
      else $error("wrap without overflow flag");
endmodule

bind uswcc_ctrl uswcc_ctrl_sva u_sva (.*);

/* File: uswcc_ctrl_tb_top.sv */
// Self-checking bench for the serial wire clock control block
module uswcc_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 1'h0, reset_n = 1'h0;
   logic [1:0] wire_mode_select = 2'h0, clock_source_select = 2'h0;
   logic clock_strobe_select = 1'h0, clock_strobe_write = 1'h0, clock_toggle_strobe = 1'h0;
   logic timer_compare_match = 1'h0, data_reg_wr = 1'h0, counter_wr = 1'h0;
   logic [7:0] data_reg_wdata = 8'h00;
   logic [3:0] counter_wdata = 4'h0;
   logic start_flag_clr = 1'h0, overflow_flag_clr = 1'h0, port_do_latch = 1'h0;
   logic port_do_dir = 1'h0, port_sda_latch = 1'h0, port_sda_dir = 1'h0;
   logic port_scl_latch = 1'h0, port_scl_dir = 1'h0;
   logic [7:0] data_reg_value;
   logic [3:0] four_bit_counter;
   logic start_condition_flag, counter_overflow_flag, do_out, do_oe, do_pullup;
   logic sda_out, sda_oe, sda_pullup, scl_out, scl_oe, scl_pullup;
   wire logic sda_in, scl_in;
   int error_cnt = 0, n_tests = 0;
   uswcc_ctrl dut (.*);
   uswcc_far_end far (.sda_oe(sda_oe), .sda_out(sda_out), .scl_oe(scl_oe), .scl_out(scl_out),
      .sda_line(sda_in), .scl_line(scl_in));
   always #2.5 ref_clk = ~ref_clk;
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic load(input logic [7:0] d, input logic [3:0] c);
      data_reg_wdata = d;
      counter_wdata = c;
      data_reg_wr = 1'h1;
      counter_wr = 1'h1;
      cyc(1);
      data_reg_wr = 1'h0;
      counter_wr = 1'h0;
      cyc(2);
   endtask
   task automatic strobe();
      clock_strobe_write = 1'h1;
      cyc(1);
      clock_strobe_write = 1'h0;
      cyc(2);
   endtask
   task automatic t_off();
      load(8'h80, 4'h0);
      clock_source_select = 2'h2;
      far.start_cond();
      cyc(10);
      chk({do_out, sda_oe, scl_oe, start_condition_flag}, 8'h00);
      far.pulses(3);
      cyc(10);
      chk(data_reg_value, 8'h07);
      chk(four_bit_counter, 4'h3);
      clock_source_select = 2'h3;
      far.pulses(1);
      cyc(10);
      chk(four_bit_counter, 4'h4);
      clock_strobe_select = 1'h1;
      far.pulses(1);
      cyc(10);
      clock_toggle_strobe = 1'h1;
      cyc(1);
      clock_toggle_strobe = 1'h0;
      cyc(2);
      chk(four_bit_counter, 4'h5);
   endtask
   task automatic t_pin();
      wire_mode_select = 2'h1;
      clock_source_select = 2'h2;
      clock_strobe_select = 1'h0;
      load(8'h40, 4'h0);
      far.pulses(1);
      cyc(10);
      chk({do_pullup, do_out, data_reg_value[7]}, 8'h01);
      far.pulses(1);
      cyc(10);
      chk({do_pullup, do_out, data_reg_value[7]}, 8'h02);
      clock_source_select = 2'h0;
      clock_strobe_select = 1'h1;
      cyc(2);
   endtask
   task automatic t_three();
      wire_mode_select = 2'h1;
      clock_source_select = 2'h0;
      port_do_dir = 1'h1;
      load(8'h80, 4'h7);
      chk({do_oe, do_out}, 8'h03);
      strobe();
      chk(four_bit_counter, 4'h8);
      chk({do_out, data_reg_value[6:0]}, 8'h01);
      clock_source_select = 2'h1;
      load(8'h01, 4'hF);
      timer_compare_match = 1'h1;
      cyc(1);
      timer_compare_match = 1'h0;
      cyc(2);
      chk({counter_overflow_flag, four_bit_counter}, 8'h10);
      overflow_flag_clr = 1'h1;
      cyc(1);
      overflow_flag_clr = 1'h0;
      cyc(1);
      chk(counter_overflow_flag, 8'h00);
   endtask
   task automatic t_two();
      port_sda_dir = 1'h1;
      port_sda_latch = 1'h1;
      port_scl_dir = 1'h1;
      port_scl_latch = 1'h1;
      load(8'h80, 4'h0);
      wire_mode_select = 2'h2;
      start_flag_clr = 1'h1;
      cyc(8);
      start_flag_clr = 1'h0;
      cyc(2);
      chk({sda_pullup, scl_pullup, sda_oe, scl_oe}, 8'h00);
      far.start_cond();
      for (int i = 0; i < 60 && start_condition_flag !== 1'h1; i++) begin
         cyc(1);
      end
      cyc(2);
      chk({start_condition_flag, scl_oe}, 8'h03);
      start_flag_clr = 1'h1;
      cyc(1);
      start_flag_clr = 1'h0;
      cyc(2);
      chk({start_condition_flag, scl_oe}, 8'h00);
      load(8'h00, 4'h0);
      chk({sda_oe, sda_out}, 8'h02);
      port_scl_latch = 1'h0;
      cyc(2);
      chk({scl_oe, scl_out}, 8'h02);
   endtask
   task automatic t_ovf();
      port_sda_dir = 1'h0;
      port_scl_latch = 1'h1;
      wire_mode_select = 2'h3;
      clock_source_select = 2'h0;
      load(8'h80, 4'hF);
      start_flag_clr = 1'h1;
      cyc(1);
      start_flag_clr = 1'h0;
      strobe();
      cyc(1);
      chk({counter_overflow_flag, scl_oe}, 8'h03);
      overflow_flag_clr = 1'h1;
      cyc(1);
      overflow_flag_clr = 1'h0;
      cyc(2);
      chk(scl_oe, 8'h00);
   endtask
   initial begin
      cyc(4);
      reset_n = 1'h1;
      cyc(8);
      t_off();
      t_three();
      t_pin();
      t_two();
      t_ovf();
      end_sim();
   end
endmodule

/* File: uswcc_far_end.sv */
// Far-end serial master model on the shared open-drain wires
module uswcc_far_end (
   input wire logic sda_oe,
   input wire logic sda_out,
   input wire logic scl_oe,
   input wire logic scl_out,
   output logic sda_line,
   output logic scl_line
);
   timeunit 1ns;
   timeprecision 100ps;
   logic sda_r = 1'h1;
   logic scl_r = 1'h1;
   assign sda_line = sda_r & (!sda_oe | sda_out);
   assign scl_line = scl_r & (!scl_oe | scl_out);
   // Clock pulses, idle high between frames
   task automatic pulses(input int n);
      repeat (n) begin
         #32 scl_r = 1'h0;
         #32 scl_r = 1'h1;
      end
   endtask
   task automatic start_cond();
      #32 sda_r = 1'h0;
      #32 sda_r = 1'h1;
   endtask
endmodule

/* File: uswcc_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
module uswcc_pin_sync
   import uswcc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic pin_async,
   output logic level_q
);

   uswcc_sync_t st_r;
   uswcc_sync_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = pin_async;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // Change accepted only once second and third stages agree
      if (st_r.s2 == st_r.s3) begin
         st_nxt.level = st_r.s3;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         st_r <= USWCC_SYNC_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level_q = st_r.level;

endmodule

/* File: uswcc_pkg.sv */
// Constants, types and reset values for the serial wire clock control block
// Operation
// [R1] Mode 00: outputs, hold, start detector off
// [R2] Three-wire: data output replaces port latch bit
// [R3] Three-wire: data-in and clock pins stay ordinary
// [R4] Master software toggles clock latch for pulses
// [R5] Two-wire: open-drain drivers enabled by direction
// [R6] SDA pulled low when data or latch zero
// [R7] SCL pulled low by latch zero or hold
// [R8] Start condition holds SCL until flag cleared
// [R9] Two-wire: inputs unchanged, pull-ups disabled
// [R10] Mode 11: counter overflow also holds SCL
// [R11] Pin clock: output updates on opposite edge
// [R12] Strobe or timer clock: output latch transparent
// [R13] Source 00: strobe write clocks register, counter
// [R14] External source: strobe select picks toggle clocking
// [R15] Counter increments once per selected clock
// [R16] Inputs work in every wire mode
// [R17] Counter wraps to zero, sets overflow flag
package uswcc_pkg;

   localparam int USWCC_DATA_W = 8;
   localparam int USWCC_CNT_W = 4;

   // Wire mode codes
   localparam logic [1:0] USWCC_WM_OFF = 2'h0;
   localparam logic [1:0] USWCC_WM_THREE = 2'h1;
   localparam logic [1:0] USWCC_WM_TWO = 2'h2;
   localparam logic [1:0] USWCC_WM_TWO_OVF = 2'h3;

   // Clock source codes
   localparam logic [1:0] USWCC_CS_SOFT = 2'h0;
   localparam logic [1:0] USWCC_CS_TIMER = 2'h1;
   localparam logic [1:0] USWCC_CS_EXT_POS = 2'h2;
   localparam logic [1:0] USWCC_CS_EXT_NEG = 2'h3;

   // Bit positions inside the select codes and the data register
   localparam int USWCC_WM_TWO_BIT = 1;
   localparam int USWCC_CS_EXT_BIT = 1;
   localparam int USWCC_CS_NEG_BIT = 0;
   localparam int USWCC_MSB = USWCC_DATA_W - 1;

   localparam logic [USWCC_CNT_W-1:0] USWCC_CNT_MAX = 4'hF;
   localparam logic [USWCC_CNT_W-1:0] USWCC_CNT_ONE = 4'h1;
   localparam logic [USWCC_CNT_W-1:0] USWCC_CNT_RST = 4'h0;
   localparam logic [USWCC_DATA_W-1:0] USWCC_DATA_RST = 8'h00;

   // Number of pin inputs passing through synchronisers
   localparam int USWCC_NUM_SYNC = 2;
   localparam int USWCC_SYNC_SDA = 0;
   localparam int USWCC_SYNC_SCL = 1;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } uswcc_sync_t;

   // Synchronisers start at the idle-high line level
   localparam uswcc_sync_t USWCC_SYNC_RST = '1;

   typedef struct packed {
      logic [USWCC_DATA_W-1:0] data;
      logic [USWCC_CNT_W-1:0] cnt;
      logic dout_latch;
      logic start_flag;
      logic ovf_flag;
      logic sda_prev;
      logic scl_prev;
      logic do_out;
      logic do_oe;
      logic do_pu;
      logic sda_out;
      logic sda_oe;
      logic sda_pu;
      logic scl_out;
      logic scl_oe;
      logic scl_pu;
   } uswcc_state_t;

   // Edge history starts at the idle-high line level, so reset gives no false edge
   localparam uswcc_state_t USWCC_STATE_RST = '{sda_prev: 1'b1, scl_prev: 1'b1, default: '0};

endpackage
